// file: psq_consts.svh
// Timing and width constants for the push-button power sequencer.
// Assumes a single 50 MHz reference clock; included by bare name.
`ifndef PSQ_CONSTS_SVH
`define PSQ_CONSTS_SVH

// Reference clock
`define PSQ_CLK_HZ 50000000
`define PSQ_CLK_PERIOD_NS 20
`define PSQ_MS_PER_S 1000

// Cycles in one millisecond time-base tick
`define PSQ_TICK_CYCLES (`PSQ_CLK_HZ / `PSQ_MS_PER_S)

// Sequencer intervals, in milliseconds
`define PSQ_ON_DB_MS 128
`define PSQ_BLANK_MS 512
`define PSQ_REL_DB_MS 32
`define PSQ_OFF_DB_MS 32
`define PSQ_KILL_DELAY_MS 128
`define PSQ_LOCKOUT_MS 256

// Least valid low time of the shutdown request, rounded up to cycles
`define PSQ_KILL_MIN_NS 30000
`define PSQ_KILL_MIN_CYC \
	((`PSQ_KILL_MIN_NS + `PSQ_CLK_PERIOD_NS - 1) / `PSQ_CLK_PERIOD_NS)

// Width of the extension inputs and of the millisecond counter
`define PSQ_EXT_W 16
`define PSQ_MS_W 18

`endif

// file: psq_pkg.sv
// Types shared by the push-button power sequencer.
// Assumes nothing of its surroundings.
package psq_pkg;

	// Sequencer states, one-hot
	typedef enum logic [6:0]
	{
		PSQ_IDLE = 7'h01,
		PSQ_BLANK = 7'h02,
		PSQ_ON_REL = 7'h04,
		PSQ_ON = 7'h08,
		PSQ_ALERT = 7'h10,
		PSQ_LOCK = 7'h20,
		PSQ_REL = 7'h40
	} psq_state_t;

endpackage

// file: psq_ms_tick.sv
// Millisecond time base: one-cycle tick every TICK_CYCLES clocks.
// Assumes the owner clears it whenever an interval restarts.
`timescale 1ns/1ps
module psq_ms_tick #(
	parameter int TICK_CYCLES = 50000
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clear,
	output logic tick
);
	localparam int CW = $clog2(TICK_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

	logic [CW-1:0] cnt_ff;
	logic tick_ff;
	wire atLast = (cnt_ff == LAST);

	// Clear restarts the phase so intervals are exact from their start
	always_ff @(posedge ref_clk)
	begin
		if (rst || clear)
		begin
			cnt_ff <= '0;
			tick_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= atLast ? '0 : cnt_ff + CW'(1);
			tick_ff <= atLast;
		end
	end

	assign tick = tick_ff;
endmodule

// file: psq_low_filter.sv
// Qualifies an active-low input: low counts only after MIN_CYC cycles.
// Assumes the input is already synchronous to ref_clk.
`timescale 1ns/1ps
module psq_low_filter #(
	parameter int MIN_CYC = 1500
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic raw_n,
	output logic validLow
)
;
	localparam int CW = $clog2(MIN_CYC + 1);
	localparam logic [CW-1:0] SAT = CW'(MIN_CYC - 1);

	logic [CW-1:0] cnt_ff;
	logic validLow_ff;
	wire rawLow = ~raw_n;
	wire longEnough = (cnt_ff == SAT);

	// Any high level drops the qualified state at once
	always_ff @(posedge ref_clk)
	begin
		if (rst || !rawLow)
		begin
			cnt_ff <= '0;
			validLow_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= longEnough ? cnt_ff : cnt_ff + CW'(1);
			validLow_ff <= longEnough;
		end
	end

	assign validLow = validLow_ff;

	// Short glitches never reach the sequencer
	property p_glitch_blocked;
		@(posedge ref_clk) disable iff (rst)
		$rose(validLow_ff) |-> $past(rawLow, 1) && $past(rawLow, 2);
	endproperty
	a_glitch_blocked: assert property (p_glitch_blocked)
		else $error("short low accepted as shutdown request");
endmodule

// file: psq_sequencer.sv
// Push-button power on/off sequencer, top level.
// Assumes push button and shutdown request are synchronous to ref_clk.
//
// How it works
// - Button held low 128ms turns supply on
// - Supply on starts 512ms blanking timer
// - Request still low at blanking end aborts
// - Inputs ignored while blanking runs
// - After blanking, debounce button release 32ms
// - Turn-off needs button low 32ms plus extension
// - Debounce done drives power-down alert low
// - Timeout 128ms plus extension releases supply
// - Low request during alert releases supply now
// - After off, debounce release then idle
// - Low request in normal operation releases supply
// - Request-driven off ignores button for 256ms
// - Supply output polarity is a build parameter
// - Request low counts only after 30us
// - Supply off from power-up until valid press
// - Shutdown timeout starts with the alert
`timescale 1ns/1ps
`include "psq_consts.svh"
module psq_sequencer #(
	parameter int TICK_CYCLES = `PSQ_TICK_CYCLES,
	parameter int ON_DB_MS = `PSQ_ON_DB_MS,
	parameter int BLANK_MS = `PSQ_BLANK_MS,
	parameter int REL_DB_MS = `PSQ_REL_DB_MS,
	parameter int OFF_DB_MS = `PSQ_OFF_DB_MS,
	parameter int KILL_DELAY_MS = `PSQ_KILL_DELAY_MS,
	parameter int LOCKOUT_MS = `PSQ_LOCKOUT_MS,
	parameter int KILL_MIN_CYC = `PSQ_KILL_MIN_CYC,
	parameter bit ACTIVE_HIGH = 1'b1
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic push_button_n,
	input wire logic shutdown_request_n,
	input wire logic [`PSQ_EXT_W-1:0] off_debounce_extend,
	input wire logic [`PSQ_EXT_W-1:0] shutdown_timeout_extend,
	output logic supply_on_out,
	output logic power_down_alert_n
);
	localparam int MW = `PSQ_MS_W;
	// Pin level that keeps the converter off
	localparam logic OFF_LEVEL = ~ACTIVE_HIGH;

	// Base plus extension, both in milliseconds
	function automatic logic [MW-1:0] msSum(
		input logic [MW-1:0] base,
		input logic [`PSQ_EXT_W-1:0] ext
	);
		msSum = base + {{(MW - `PSQ_EXT_W){1'b0}}, ext};
	endfunction

	// True on the tick that completes the interval
	function automatic logic reached(
		input logic tick,
		input logic [MW-1:0] cnt,
		input logic [MW-1:0] target
	);
		reached = tick && ((cnt + MW'(1)) >= target);
	endfunction

	psq_pkg::psq_state_t state_ff;
	psq_pkg::psq_state_t nxt_state;
	logic [MW-1:0] msCnt_ff;
	logic [MW-1:0] nxt_msCnt;
	logic [MW-1:0] target;
	logic supplyPin_ff;
	logic alertN_ff;
	logic msTick;
	logic killLow;
	logic clrTimer;
	logic done;

	wire pbLow = ~push_button_n;
	wire inIdle = (state_ff == psq_pkg::PSQ_IDLE);
	wire inBlank = (state_ff == psq_pkg::PSQ_BLANK);
	wire inOnRel = (state_ff == psq_pkg::PSQ_ON_REL);
	wire inOn = (state_ff == psq_pkg::PSQ_ON);
	wire inAlert = (state_ff == psq_pkg::PSQ_ALERT);
	wire inLock = (state_ff == psq_pkg::PSQ_LOCK);
	wire inRel = (state_ff == psq_pkg::PSQ_REL);

	// Supply is on in every state from blanking through the alert
	wire supplyOnNow = inBlank | inOnRel | inOn | inAlert;
	wire nxtSupplyOn = (nxt_state == psq_pkg::PSQ_BLANK) ||
		(nxt_state == psq_pkg::PSQ_ON_REL) ||
		(nxt_state == psq_pkg::PSQ_ON) ||
		(nxt_state == psq_pkg::PSQ_ALERT);

	// Shutdown request is qualified against glitches first
	psq_low_filter #(
		.MIN_CYC(KILL_MIN_CYC)
	)
	u_killFilter
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.raw_n(shutdown_request_n),
		.validLow(killLow)
	);

	// Millisecond base, rephased whenever an interval restarts
	psq_ms_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	)
	u_msTick
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.clear(clrTimer),
		.tick(msTick)
	);

	// Interval length for the current state
	always_comb
	begin
		target = MW'(ON_DB_MS);
		unique case (state_ff)
			psq_pkg::PSQ_IDLE: target = MW'(ON_DB_MS);
			psq_pkg::PSQ_BLANK: target = MW'(BLANK_MS);
			psq_pkg::PSQ_ON_REL: target = MW'(REL_DB_MS);
			psq_pkg::PSQ_ON: target = msSum(MW'(OFF_DB_MS),
				off_debounce_extend);
			psq_pkg::PSQ_ALERT: target = msSum(MW'(KILL_DELAY_MS),
				shutdown_timeout_extend);
			psq_pkg::PSQ_LOCK: target = MW'(LOCKOUT_MS);
			psq_pkg::PSQ_REL: target = MW'(REL_DB_MS);
		endcase
	end

	assign done = reached(msTick, msCnt_ff, target);

	// Button level that breaks a debounce and restarts it
	wire restart = ((inIdle | inOn) & ~pbLow) |
		((inOnRel | inRel) & pbLow);

	// Next state; lockout looks at nothing but time, blanking only at the request on its last tick
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			psq_pkg::PSQ_IDLE:
				if (pbLow && done)
					nxt_state = psq_pkg::PSQ_BLANK;
			psq_pkg::PSQ_BLANK:
				if (done)
					nxt_state = killLow ? psq_pkg::PSQ_REL :
						psq_pkg::PSQ_ON_REL;
			psq_pkg::PSQ_ON_REL:
				if (!pbLow && done)
					nxt_state = psq_pkg::PSQ_ON;
			psq_pkg::PSQ_ON:
				if (killLow)
					nxt_state = psq_pkg::PSQ_LOCK;
				else if (pbLow && done)
					nxt_state = psq_pkg::PSQ_ALERT;
			psq_pkg::PSQ_ALERT:
				if (killLow)
					nxt_state = psq_pkg::PSQ_LOCK;
				else if (done)
					nxt_state = psq_pkg::PSQ_REL;
			psq_pkg::PSQ_LOCK:
				if (done)
					nxt_state = psq_pkg::PSQ_REL;
			psq_pkg::PSQ_REL:
				if (!pbLow && done)
					nxt_state = psq_pkg::PSQ_IDLE;
		endcase
	end

	// Counter restarts on entry to a state and on a broken debounce
	assign clrTimer = (nxt_state != state_ff) || restart;
	assign nxt_msCnt = clrTimer ? '0 :
		(msTick ? msCnt_ff + MW'(1) : msCnt_ff);

	// State and counter
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_ff <= psq_pkg::PSQ_IDLE;
			msCnt_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			msCnt_ff <= nxt_msCnt;
		end
	end

	// Pins follow the next state so both change with the state
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			supplyPin_ff <= OFF_LEVEL;
			alertN_ff <= 1'b1;
		end
		else
		begin
			supplyPin_ff <= nxtSupplyOn ^ OFF_LEVEL;
			alertN_ff <= (nxt_state != psq_pkg::PSQ_ALERT);
		end
	end

	assign supply_on_out = supplyPin_ff;
	assign power_down_alert_n = alertN_ff;

	// Checks, all in the reference clock domain
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	wire supplyIsOn = (supply_on_out != OFF_LEVEL);

	sequence s_press_done;
		inIdle && pbLow && done;
	endsequence

	sequence s_blank_end;
		inBlank && done;
	endsequence

	// Turn-on only after a completed on-debounce
	property p_turn_on;
		$rose(supplyIsOn) |-> $past(inIdle) && $past(pbLow) &&
			$past(msCnt_ff) == MW'(ON_DB_MS - 1);
	endproperty
	a_turn_on: assert property (p_turn_on)
		else $error("supply enabled without full on-debounce");

	// A completed press enters blanking with the supply on
	property p_blank_start;
		s_press_done |=> inBlank && supplyIsOn && msCnt_ff == '0;
	endproperty
	a_blank_start: assert property (p_blank_start)
		else $error("blanking did not start with supply on");

	// Blanking holds regardless of the inputs until it ends
	property p_blank_holds;
		inBlank && !done |=> inBlank && supplyIsOn;
	endproperty
	a_blank_holds: assert property (p_blank_holds)
		else $error("blanking left early");

	// Request still low at blanking end aborts power-on
	property p_abort;
		s_blank_end ##0 killLow |=> !supplyIsOn && inRel;
	endproperty
	a_abort: assert property (p_abort)
		else $error("power-on not aborted");

	// Turn-off debounce completion raises the alert
	property p_alert;
		inOn && !killLow && pbLow && done |=>
			!power_down_alert_n && supplyIsOn && msCnt_ff == '0;
	endproperty
	a_alert: assert property (p_alert)
		else $error("alert not driven after off-debounce");

	// Timeout expiry releases the supply
	property p_timeout;
		inAlert && !killLow && done |=> !supplyIsOn && power_down_alert_n;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("shutdown timeout did not release supply");

	// Qualified request low releases at once and starts lockout
	property p_kill_off;
		(inOn || inAlert) && killLow |=> !supplyIsOn && inLock;
	endproperty
	a_kill_off: assert property (p_kill_off)
		else $error("shutdown request did not release supply");

	// Lockout ignores the button entirely
	property p_lockout;
		inLock && !done |=> inLock && !supplyIsOn;
	endproperty
	a_lockout: assert property (p_lockout)
		else $error("lockout ended early");

	// Alert is high whenever the supply is off
	property p_alert_idle;
		!supplyIsOn |-> power_down_alert_n;
	endproperty
	a_alert_idle: assert property (p_alert_idle)
		else $error("alert low with supply off");

	// Pin level tracks the state under either build polarity
	property p_pin_state;
		supply_on_out == (supplyOnNow ? ACTIVE_HIGH : OFF_LEVEL);
	endproperty
	a_pin_state: assert property (p_pin_state)
		else $error("supply pin level disagrees with state");

	// Post-blanking release debounce waits out a held button
	property p_onrel_hold;
		inOnRel && pbLow |=> inOnRel && supplyIsOn;
	endproperty
	a_onrel_hold: assert property (p_onrel_hold)
		else $error("held button ended release debounce");

	// Post-off release debounce keeps the supply off while held
	property p_rel_hold;
		inRel && pbLow |=> inRel && !supplyIsOn && power_down_alert_n;
	endproperty
	a_rel_hold: assert property (p_rel_hold)
		else $error("held button left the off debounce");
endmodule

// file: psq_proc_model.sv
// Processor model that drives the shutdown request.
// Assumes the bench sets the boot and answer delays in cycles.
`timescale 1ns/1ps
module psq_proc_model #(
	parameter bit ACTIVE_HIGH = 1'b1
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic supply_on_out,
	input wire logic power_down_alert_n,
	input wire logic [15:0] bootCyc,
	input wire logic [15:0] ackCyc,
	input wire logic glitchN,
	output logic shutdown_request_n
);
	logic [15:0] upCnt_ff;
	logic [15:0] ackCnt_ff;
	logic reqHigh;
	logic ackLow;
	// Unpowered processor cannot drive, so its request reads low
	always_ff @(posedge ref_clk)
	begin
		if (rst || supply_on_out !== ACTIVE_HIGH)
		begin
			upCnt_ff <= 16'h0;
			ackCnt_ff <= 16'h0;
		end
		else
		begin
			upCnt_ff <= upCnt_ff + 16'h1;
			ackCnt_ff <= ackCnt_ff + {15'h0, !power_down_alert_n};
		end
	end
	// Zero boot delay never raises it, which forces an abort
	assign reqHigh = bootCyc != 16'h0 && upCnt_ff >= bootCyc;
	// Zero answer delay models a hung processor
	assign ackLow = ackCyc != 16'h0 && ackCnt_ff >= ackCyc;
	assign shutdown_request_n = reqHigh && !ackLow && glitchN;
endmodule

// file: push_button_power_sequencer_bench.sv
// Self-checking bench for the push-button power sequencer.
// Assumes shortened intervals: one ms tick is TK cycles.
`timescale 1ns/1ps
module push_button_power_sequencer_bench;
	localparam int TK = 10;
	localparam int ON_DB = 8;
	localparam int BLANK = 16;
	localparam int REL_DB = 2;
	localparam int OFF_DB = 2;
	localparam int KDLY = 4;
	localparam int LOCK = 6;
	localparam int KMIN = 4;
	localparam int TOL = 3;
	localparam bit AH = 1'b1;
	localparam logic [1:0] V_ON = {AH, 1'b1};
	localparam logic [1:0] V_ALERT = {AH, 1'b0};
	localparam logic [1:0] V_OFF = {!AH, 1'b1};
	typedef struct { logic [1:0] v; int at; } psq_note_t;
	psq_note_t notes[$];
	psq_note_t n;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic pbN = 1'b1;
	logic glitchN = 1'b1;
	logic [15:0] offExt = 16'h0;
	logic [15:0] killExt = 16'h0;
	logic [15:0] bootCyc = 16'h28;
	logic [15:0] ackCyc = 16'h0;
	logic reqN;
	logic supply;
	logic alertN;
	logic supplyLow;
	logic [1:0] prevOut = V_OFF;
	int cyc = 0;
	int err_count = 0;
	int compares = 0;
	int seed = 19;
	int t0;

	psq_sequencer #(.TICK_CYCLES(TK), .ON_DB_MS(ON_DB), .BLANK_MS(BLANK),
		.REL_DB_MS(REL_DB), .OFF_DB_MS(OFF_DB), .KILL_DELAY_MS(KDLY),
		.LOCKOUT_MS(LOCK), .KILL_MIN_CYC(KMIN), .ACTIVE_HIGH(AH)) u_dut (
		.ref_clk(ref_clk), .rst(rst), .push_button_n(pbN),
		.shutdown_request_n(reqN), .off_debounce_extend(offExt),
		.shutdown_timeout_extend(killExt), .supply_on_out(supply),
		.power_down_alert_n(alertN));
	psq_proc_model #(.ACTIVE_HIGH(AH)) u_proc (.ref_clk(ref_clk),
		.rst(rst), .supply_on_out(supply), .power_down_alert_n(alertN),
		.bootCyc(bootCyc), .ackCyc(ackCyc), .glitchN(glitchN),
		.shutdown_request_n(reqN));
	// Low-true variant on the same inputs, its supply pin held to the same notes
	psq_sequencer #(.TICK_CYCLES(TK), .ON_DB_MS(ON_DB), .BLANK_MS(BLANK),
		.REL_DB_MS(REL_DB), .OFF_DB_MS(OFF_DB), .KILL_DELAY_MS(KDLY),
		.LOCKOUT_MS(LOCK), .KILL_MIN_CYC(KMIN), .ACTIVE_HIGH(!AH))
		u_dutLow (
		.ref_clk(ref_clk), .rst(rst), .push_button_n(pbN),
		.shutdown_request_n(reqN), .off_debounce_extend(offExt),
		.shutdown_timeout_extend(killExt), .supply_on_out(supplyLow),
		.power_down_alert_n());

	// Clock and cycle count
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;

	task automatic clk(input int k);
		repeat (k) @(posedge ref_clk);
	endtask

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic expect_at(input logic [1:0] v, input int at);
		notes.push_back('{v, at});
	endtask

	task automatic end_test(input string name);
		check("pending notes", 32'(notes.size()), 32'h0);
		$display("test %s done", name);
	endtask

	// Press held through blanking, which must not react to it
	task automatic power_on(input bit abort);
		pbN <= 1'b0;
		t0 = cyc + ON_DB * TK + 2;
		expect_at(V_ON, t0);
		if (abort)
			expect_at(V_OFF, t0 + BLANK * TK);
		clk((ON_DB + BLANK) * TK + 8);
		pbN <= 1'b1;
		clk(REL_DB * TK + 8);
	endtask

	// Bounced turn-off press, answered by the processor or timed out
	task automatic press_off(input int oExt, input int kExt, input int ack);
		offExt <= 16'(oExt);
		killExt <= 16'(kExt);
		ackCyc <= 16'(ack);
		pbN <= 1'b0;
		clk(OFF_DB * TK - 5);
		pbN <= 1'b1;
		clk(1);
		pbN <= 1'b0;
		t0 = cyc + (OFF_DB + oExt) * TK + 2;
		expect_at(V_ALERT, t0);
		if (ack != 0)
			expect_at(V_OFF, t0 + ack + KMIN + 2);
		else
			expect_at(V_OFF, t0 + (KDLY + kExt) * TK);
		// Button kept low across the lockout must not restart power
		clk((OFF_DB + oExt + KDLY + kExt + LOCK + ON_DB) * TK + 10);
		pbN <= 1'b1;
		clk(REL_DB * TK + 8);
	endtask

	// Each output change takes the oldest note; settled at the low phase
	always @(negedge ref_clk)
	begin
		if (!rst && {supply, alertN} !== prevOut)
		begin
			if (notes.size() == 0)
				check("quiet outputs", {30'h0, supply, alertN}, {30'h0, prevOut});
			else
			begin
				n = notes.pop_front();
				check("outputs", {30'h0, supply, alertN}, {30'h0, n.v});
				check("low-true", {31'h0, supplyLow}, {31'h0, !n.v[1]});
				t0 = (cyc - n.at <= TOL && n.at - cyc <= TOL) ? n.at : cyc;
				check("edge cycle", 32'(t0), 32'(n.at));
			end
		end
		prevOut = {supply, alertN};
	end

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Hang guard, far beyond the nearly two thousand cycles the tests need
	initial
	begin
		clk(20000);
		err_count++;
		print_verdict();
	end

	// Main sequence
	initial
	begin
		clk(20);
		rst <= 1'b0;
		clk(2);
		// Outputs are read settled, away from the edge that launches them
		@(negedge ref_clk);
		check("supply after reset", {31'h0, supply}, {31'h0, !AH});
		check("alert after reset", {31'h0, alertN}, 32'h1);
		check("low-true reset", {31'h0, supplyLow}, {31'h0, AH});
		clk(1);
		pbN <= 1'b0;
		clk(5 * TK);
		pbN <= 1'b1;
		clk(1);
		power_on(1'b0);
		end_test("turn on");
		press_off($unsigned($random(seed)) % 3 + 1, 0, 25);
		end_test("answered off");
		power_on(1'b0);
		press_off(0, $unsigned($random(seed)) % 3 + 1, 0);
		end_test("timeout off");
		bootCyc <= 16'h0;
		power_on(1'b1);
		end_test("abort");
		bootCyc <= 16'h28;
		clk(1);
		power_on(1'b0);
		repeat (4)
		begin
			glitchN <= 1'b0;
			clk($unsigned($random(seed)) % (KMIN - 1) + 1);
			glitchN <= 1'b1;
			clk(3);
		end
		glitchN <= 1'b0;
		expect_at(V_OFF, cyc + KMIN + 2);
		clk(KMIN + 10);
		glitchN <= 1'b1;
		clk((LOCK + REL_DB) * TK + 8);
		end_test("request off");
		print_verdict();
	end
endmodule
